// >>> core/cisad_addsub.sv
// 32-bit adder/subtractor giving carry (not-borrow on subtract) and overflow
// assumes purely combinational use inside one clock cycle
`timescale 1ns/10ps
`default_nettype none

module cisad_addsub (
	input wire logic [31:0] a,
	input wire logic [31:0] b,
	input wire logic sub,
	output logic [31:0] sum,
	output logic carry,
	output logic overflow
);

	logic [31:0] b_eff;
	logic [32:0] total;

	assign b_eff = sub ? ~b : b;
	assign total = {1'b0, a} + {1'b0, b_eff} + {32'h0, sub};
	assign sum = total[31:0];
	assign carry = total[32];
	// overflow when both addends share a sign that the sum lacks
	assign overflow = (a[31] == b_eff[31]) && (sum[31] != a[31]);

endmodule // cisad_addsub

`default_nettype wire

// >>> core/cisad_core.sv
// decode and execute of the shift-immediate, add/subtract and
// immediate-operation compact formats.
// assumes a register file with two combinational read ports and one
// write port, and a flag register, all on core_clk.
`timescale 1ns/10ps
`default_nettype none

module cisad_core (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic instr_valid,
	input wire logic [15:0] instr,
	output logic instr_ready,
	output logic [2:0] rd_addr_a,
	output logic [2:0] rd_addr_b,
	input wire logic [31:0] rd_data_a,
	input wire logic [31:0] rd_data_b,
	input wire logic [3:0] flags_cur,
	output logic wr_en,
	output logic [2:0] wr_addr,
	output logic [31:0] wr_data,
	output logic flags_we,
	output logic [3:0] flags_out,
	output logic instr_done,
	output logic foreign_instr,
	output cisad_pkg::cisad_fmt_t exec_fmt
);

	cisad_pkg::cisad_state_t st_reg;
	cisad_pkg::cisad_state_t st_next;
	cisad_pkg::cisad_fmt_t fmt_dec;

	logic accept;
	logic [1:0] op_code;
	logic [31:0] opa;
	logic [31:0] opb;
	logic [3:0] flg;
	logic [31:0] sh_res;
	logic sh_c;
	logic [31:0] as_b;
	logic as_sub;
	logic [31:0] as_sum;
	logic as_c;
	logic as_v;
	logic [31:0] imm8;
	logic [31:0] imm3;

	// one instruction per cycle: there is no multi-cycle operation here
	assign instr_ready = 1'b1;
	assign accept = instr_valid && instr_ready;
	assign op_code = instr[cisad_pkg::OP_HI:cisad_pkg::OP_LO];
	assign imm8 = {24'h0, instr[cisad_pkg::IMM8_HI:cisad_pkg::IMM8_LO]};
	assign imm3 = {29'h0, instr[cisad_pkg::SRC2_HI:cisad_pkg::SRC2_LO]};

	// format recognition
	always_comb begin
		fmt_dec = cisad_pkg::FMT_NONE;
		if (instr[cisad_pkg::TOP_HI -: 5] == cisad_pkg::TOP_ADDSUB) begin
			fmt_dec = cisad_pkg::FMT_ADDSUB;
		end else if (instr[cisad_pkg::TOP_HI -: 3] == cisad_pkg::TOP_SHIFT) begin
			fmt_dec = cisad_pkg::FMT_SHIFT;
		end else if (instr[cisad_pkg::TOP_HI -: 3] == cisad_pkg::TOP_IMM) begin
			fmt_dec = cisad_pkg::FMT_IMM;
		end
	end

	// 3-bit fields only, so nothing above register 7 can be named
	always_comb begin
		rd_addr_a = instr[cisad_pkg::SRC_HI:cisad_pkg::SRC_LO];
		rd_addr_b = instr[cisad_pkg::SRC2_HI:cisad_pkg::SRC2_LO];
		if (fmt_dec == cisad_pkg::FMT_IMM) begin
			rd_addr_a = instr[cisad_pkg::IDST_HI:cisad_pkg::IDST_LO];
		end
	end

	// forward last result: the register file writes it only at the end
	// of this cycle, so a back-to-back reader would otherwise see stale data
	always_comb begin
		opa = rd_data_a;
		opb = rd_data_b;
		if (st_reg.wr_en && st_reg.wr_addr == rd_addr_a) begin
			opa = st_reg.wr_data;
		end
		if (st_reg.wr_en && st_reg.wr_addr == rd_addr_b) begin
			opb = st_reg.wr_data;
		end
		flg = st_reg.flags_we ? st_reg.flags : flags_cur;
	end

	// shared adder operands
	always_comb begin
		as_b = opb;
		as_sub = instr[cisad_pkg::SUBF_BIT];
		if (fmt_dec == cisad_pkg::FMT_IMM) begin
			as_b = imm8;
			as_sub = (op_code != cisad_pkg::IMM_ADD_OP);
		end else if (instr[cisad_pkg::IMMF_BIT]) begin
			as_b = imm3;
		end
	end

	cisad_shifter u_shift (
		.value(opa),
		.amount(instr[cisad_pkg::AMT_HI:cisad_pkg::AMT_LO]),
		.kind(op_code),
		.carry_in(flg[cisad_pkg::FLAG_C]),
		.result(sh_res),
		.carry_out(sh_c)
	);

	cisad_addsub u_addsub (
		.a(opa),
		.b(as_b),
		.sub(as_sub),
		.sum(as_sum),
		.carry(as_c),
		.overflow(as_v)
	);

	always_comb begin
		st_next = st_reg;
		st_next.wr_en = 1'b0;
		st_next.flags_we = 1'b0;
		st_next.done = 1'b0;
		st_next.foreign = 1'b0;
		if (accept) begin
			st_next.done = 1'b1;
			st_next.fmt = fmt_dec;
			case (fmt_dec)
				cisad_pkg::FMT_SHIFT: begin
					st_next.wr_en = 1'b1;
					st_next.wr_addr = instr[cisad_pkg::DST_HI:cisad_pkg::DST_LO];
					st_next.wr_data = sh_res;
					st_next.flags_we = 1'b1;
					// shifts leave overflow alone
					st_next.flags = {sh_res[31], sh_res == 32'h0, sh_c,
						flg[cisad_pkg::FLAG_V]};
				end
				cisad_pkg::FMT_ADDSUB: begin
					st_next.wr_en = 1'b1;
					st_next.wr_addr = instr[cisad_pkg::DST_HI:cisad_pkg::DST_LO];
					st_next.wr_data = as_sum;
					st_next.flags_we = 1'b1;
					st_next.flags = {as_sum[31], as_sum == 32'h0, as_c, as_v};
				end
				cisad_pkg::FMT_IMM: begin
					st_next.wr_addr = instr[cisad_pkg::IDST_HI:cisad_pkg::IDST_LO];
					st_next.flags_we = 1'b1;
					if (op_code == cisad_pkg::IMM_MOVE_OP) begin
						st_next.wr_en = 1'b1;
						st_next.wr_data = imm8;
						// a move touches only sign and zero
						st_next.flags = {imm8[31], imm8 == 32'h0,
							flg[cisad_pkg::FLAG_C], flg[cisad_pkg::FLAG_V]};
					end else begin
						// compare writes nothing back
						st_next.wr_en = (op_code != cisad_pkg::compare_op);
						st_next.wr_data = as_sum;
						st_next.flags = {as_sum[31], as_sum == 32'h0, as_c,
							as_v};
					end
				end
				default: begin
					// other formats belong to other decoders; flags and
					// registers stay untouched here
					st_next.foreign = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			st_reg <= cisad_pkg::STATE_RESET;
		end else begin
			st_reg <= st_next;
		end
	end

	assign wr_en = st_reg.wr_en;
	assign wr_addr = st_reg.wr_addr;
	assign wr_data = st_reg.wr_data;
	assign flags_we = st_reg.flags_we;
	assign flags_out = st_reg.flags;
	assign instr_done = st_reg.done;
	assign foreign_instr = st_reg.foreign;
	assign exec_fmt = st_reg.fmt;

	// ---- assertions ----
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);

	sequence s_shift(logic [1:0] k);
		accept && fmt_dec == cisad_pkg::FMT_SHIFT && op_code == k;
	endsequence

	sequence s_addsub(logic [1:0] oi);
		accept && fmt_dec == cisad_pkg::FMT_ADDSUB && instr[10:9] == oi;
	endsequence

	sequence s_imm(logic [1:0] k);
		accept && fmt_dec == cisad_pkg::FMT_IMM && op_code == k;
	endsequence

	a_shl_write: assert property (
		s_shift(2'h0) |=> wr_en &&
		wr_data == ($past(opa) << $past(instr[10:6])))
		else $error("left shift result wrong");

	a_shr_write: assert property (
		s_shift(2'h1) ##0 instr[10:6] != 5'h00 |=> wr_en &&
		wr_data == ($past(opa) >> $past(instr[10:6])))
		else $error("logical right shift result wrong");

	a_sar_write: assert property (
		s_shift(2'h2) |=> wr_en && (($past(instr[10:6]) == 5'h00) ?
		wr_data == {32{$past(opa[31])}} :
		wr_data == 32'($signed($past(opa)) >>> $past(instr[10:6]))))
		else $error("arithmetic right shift result wrong");

	a_flags_update: assert property (
		accept && fmt_dec != cisad_pkg::FMT_NONE |=> flags_we &&
		(!wr_en || (flags_out[3] == wr_data[31] &&
		flags_out[2] == (wr_data == 32'h0))))
		else $error("flags not updated from result");

	a_add_reg: assert property (
		s_addsub(2'h0) |=> wr_en && wr_addr == $past(instr[2:0]) &&
		wr_data == 32'($past(opa) + $past(opb)))
		else $error("register add wrong");

	a_add_small: assert property (
		s_addsub(2'h2) |=>
		wr_data == 32'($past(opa) + {29'h0, $past(instr[8:6])}))
		else $error("small immediate add wrong");

	a_sub_reg: assert property (
		s_addsub(2'h1) |=> wr_en &&
		wr_data == 32'($past(opa) - $past(opb)))
		else $error("register subtract wrong");

	a_sub_small: assert property (
		s_addsub(2'h3) |=>
		wr_data == 32'($past(opa) - {29'h0, $past(instr[8:6])}))
		else $error("small immediate subtract wrong");

	a_move_byte: assert property (
		s_imm(2'h0) |=> wr_en && flags_we &&
		wr_data == {24'h0, $past(instr[7:0])} &&
		flags_out[1:0] == $past(flg[1:0]))
		else $error("byte move wrong");

	a_compare_only: assert property (
		s_imm(2'h1) |=> !wr_en && flags_we &&
		flags_out[1] == ($past(opa) >= {24'h0, $past(instr[7:0])}))
		else $error("compare wrote a register or bad carry");

	a_add_byte: assert property (
		s_imm(2'h2) |=> wr_en && wr_addr == $past(instr[10:8]) &&
		wr_data == 32'($past(opa) + {24'h0, $past(instr[7:0])}))
		else $error("byte add wrong");

	a_sub_byte: assert property (
		s_imm(2'h3) |=> wr_en && wr_addr == $past(instr[10:8]) &&
		wr_data == 32'($past(opa) - {24'h0, $past(instr[7:0])}))
		else $error("byte subtract wrong");

	a_single_cycle: assert property (
		accept |-> ##1 instr_done ##0 (wr_en || flags_we || foreign_instr))
		else $error("instruction not finished in one cycle");

	a_foreign_quiet: assert property (
		accept && fmt_dec == cisad_pkg::FMT_NONE |=>
		foreign_instr && !flags_we && !wr_en)
		else $error("foreign instruction touched flags");

	a_fmt_decode: assert property (
		accept && instr[15:11] == 5'h03 |=>
		exec_fmt == cisad_pkg::FMT_ADDSUB)
		else $error("add/subtract format misdecoded");

	a_src_select: assert property (
		accept && fmt_dec != cisad_pkg::FMT_IMM |->
		rd_addr_a == instr[5:3] && rd_addr_b == instr[8:6])
		else $error("source register field misrouted");

	a_imm_select: assert property (
		accept && fmt_dec == cisad_pkg::FMT_IMM |->
		rd_addr_a == instr[10:8])
		else $error("immediate format register misrouted");

	a_shift_dest: assert property (
		accept && fmt_dec == cisad_pkg::FMT_SHIFT |=>
		wr_addr == $past(instr[2:0]) && exec_fmt == cisad_pkg::FMT_SHIFT)
		else $error("shift destination wrong");

	a_hireg_move: assert property (
		accept && instr[15:8] == 8'h46 |=>
		foreign_instr && !flags_we && !wr_en)
		else $error("high register move touched flags");

	a_idle_quiet: assert property (
		!accept |=> !instr_done && !wr_en && !flags_we && !foreign_instr)
		else $error("output pulse without an instruction");

	a_shl_carry: assert property (
		s_shift(2'h0) ##0 instr[10:6] != 5'h00 |=>
		flags_out[1] == $past(opa[5'(6'h20 - {1'b0, instr[10:6]})]))
		else $error("left shift carry wrong");

	a_shr_carry: assert property (
		s_shift(2'h1) ##0 instr[10:6] != 5'h00 |=>
		flags_out[1] == $past(opa[5'(instr[10:6] - 5'h01)]))
		else $error("right shift carry wrong");

	a_shr_zero: assert property (
		s_shift(2'h1) ##0 instr[10:6] == 5'h00 |=>
		wr_data == 32'h0 && flags_out[1] == $past(opa[31]))
		else $error("right shift by thirty-two wrong");

endmodule // cisad_core

`default_nettype wire

// >>> core/cisad_pkg.sv
// constants and types shared by the compact shift/add/sub decode block
// assumes a 32-bit datapath, eight low registers and NZCV flags
`default_nettype none

package cisad_pkg;

	localparam int unsigned DATA_W = 32;
	localparam int unsigned REG_AW = 3;
	localparam int unsigned FLAG_W = 4;

	// flag positions inside the 4-bit flag word
	localparam int unsigned FLAG_N = 3;
	localparam int unsigned FLAG_Z = 2;
	localparam int unsigned FLAG_C = 1;
	localparam int unsigned FLAG_V = 0;

	// format recognition patterns
	localparam logic [2:0] TOP_SHIFT = 3'h0;
	localparam logic [4:0] TOP_ADDSUB = 5'h03;
	localparam logic [2:0] TOP_IMM = 3'h1;

	// field positions
	localparam int unsigned TOP_HI = 15;
	localparam int unsigned OP_HI = 12;
	localparam int unsigned OP_LO = 11;
	localparam int unsigned AMT_HI = 10;
	localparam int unsigned AMT_LO = 6;
	localparam int unsigned SRC_HI = 5;
	localparam int unsigned SRC_LO = 3;
	localparam int unsigned DST_HI = 2;
	localparam int unsigned DST_LO = 0;
	localparam int unsigned IMMF_BIT = 10;
	localparam int unsigned SUBF_BIT = 9;
	localparam int unsigned SRC2_HI = 8;
	localparam int unsigned SRC2_LO = 6;
	localparam int unsigned IDST_HI = 10;
	localparam int unsigned IDST_LO = 8;
	localparam int unsigned IMM8_HI = 7;
	localparam int unsigned IMM8_LO = 0;

	// operation codes
	localparam logic [1:0] shift_left_logical_op = 2'h0;
	localparam logic [1:0] shift_right_logical_op = 2'h1;
	localparam logic [1:0] shift_right_arith_op = 2'h2;
	localparam logic [1:0] IMM_MOVE_OP = 2'h0;
	localparam logic [1:0] compare_op = 2'h1;
	localparam logic [1:0] IMM_ADD_OP = 2'h2;
	localparam logic [1:0] IMM_SUB_OP = 2'h3;

	// execution cycles of one data-processing instruction
	localparam int unsigned EXEC_CYCLES = 1;

	typedef enum logic [1:0] {
		FMT_NONE,
		FMT_SHIFT,
		FMT_ADDSUB,
		FMT_IMM
	} cisad_fmt_t;

	typedef struct packed {
		logic wr_en;
		logic [REG_AW-1:0] wr_addr;
		logic [DATA_W-1:0] wr_data;
		logic flags_we;
		logic [FLAG_W-1:0] flags;
		logic done;
		logic foreign;
		cisad_fmt_t fmt;
	} cisad_state_t;

	localparam cisad_state_t STATE_RESET = '0;

endpackage

`default_nettype wire

// >>> core/cisad_shifter.sv
// immediate-amount barrel shifter with carry out
// assumes kind is one of the three shift codes; amount zero means the
// special encodings (unchanged for left, 32 for the right shifts)
`timescale 1ns/10ps
`default_nettype none

module cisad_shifter (
	input wire logic [31:0] value,
	input wire logic [4:0] amount,
	input wire logic [1:0] kind,
	input wire logic carry_in,
	output logic [31:0] result,
	output logic carry_out
);

	logic [4:0] left_idx;
	logic [4:0] right_idx;

	assign left_idx = 5'(6'h20 - {1'b0, amount});
	assign right_idx = 5'(amount - 5'h01);

	always_comb begin
		result = value;
		carry_out = carry_in;
		case (kind)
			cisad_pkg::shift_left_logical_op: begin
				if (amount != 5'h00) begin
					result = value << amount;
					carry_out = value[left_idx];
				end
			end
			cisad_pkg::shift_right_logical_op: begin
				result = (amount == 5'h00) ? 32'h0 : value >> amount;
				carry_out = (amount == 5'h00) ? value[31] : value[right_idx];
			end
			cisad_pkg::shift_right_arith_op: begin
				result = (amount == 5'h00) ? {32{value[31]}} :
					32'($signed(value) >>> amount);
				carry_out = (amount == 5'h00) ? value[31] : value[right_idx];
			end
			default: begin
				result = value;
				carry_out = carry_in;
			end
		endcase
	end

endmodule // cisad_shifter

`default_nettype wire

// >>> sim/cisad_regfile_model.sv
// low register file and flag register facing the decode block
// assumes combinational reads and writes on the rising core_clk edge
`timescale 1ns/10ps
`default_nettype none

module cisad_regfile_model (
	input wire logic core_clk,
	input wire logic [2:0] rd_addr_a,
	input wire logic [2:0] rd_addr_b,
	output logic [31:0] rd_data_a,
	output logic [31:0] rd_data_b,
	output logic [3:0] flags_cur,
	input wire logic wr_en,
	input wire logic [2:0] wr_addr,
	input wire logic [31:0] wr_data,
	input wire logic flags_we,
	input wire logic [3:0] flags_out
);
	// only eight entries: a wider address would be a decode fault
	logic [31:0] regs [8];
	logic [3:0] flags_reg;

	initial begin
		foreach (regs[i]) regs[i] = 32'h0;
		flags_reg = 4'h0;
	end

	assign rd_data_a = regs[rd_addr_a];
	assign rd_data_b = regs[rd_addr_b];
	assign flags_cur = flags_reg;

	always @(posedge core_clk) begin
		if (wr_en) regs[wr_addr] <= wr_data;
		if (flags_we) flags_reg <= flags_out;
	end
endmodule // cisad_regfile_model

`default_nettype wire

// >>> sim/tb.sv
// self-checking bench for the compact shift/add/sub decode block
// assumes the register file model beside it starts with all zeros
`timescale 1ns/10ps
`default_nettype none

module tb;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic instr_valid = 1'b0;
	logic [15:0] instr = 16'h0000;
	logic instr_ready, wr_en, flags_we, instr_done, foreign_instr;
	logic [2:0] rd_addr_a, rd_addr_b, wr_addr;
	logic [31:0] rd_data_a, rd_data_b, wr_data;
	logic [3:0] flags_cur, flags_out;
	cisad_pkg::cisad_fmt_t exec_fmt;
	logic [31:0] g_reg [8] = '{default: 32'h0};
	logic [3:0] g_flg = 4'h0;
	logic e_done = 1'b0, e_we = 1'b0, e_fwe = 1'b0, e_fgn = 1'b0;
	logic [2:0] e_addr = 3'h0;
	logic [31:0] e_data = 32'h0;
	logic [3:0] e_flg = 4'h0;
	logic [1:0] e_fmt = 2'h0;
	int err_total = 0;
	int n_tests = 0;

	cisad_core u_cisad_core (.core_clk(core_clk), .rst(rst),
		.instr_valid(instr_valid), .instr(instr), .instr_ready(instr_ready),
		.rd_addr_a(rd_addr_a), .rd_addr_b(rd_addr_b), .rd_data_a(rd_data_a),
		.rd_data_b(rd_data_b), .flags_cur(flags_cur), .wr_en(wr_en),
		.wr_addr(wr_addr), .wr_data(wr_data), .flags_we(flags_we),
		.flags_out(flags_out), .instr_done(instr_done),
		.foreign_instr(foreign_instr), .exec_fmt(exec_fmt));

	cisad_regfile_model u_cisad_regfile_model (.core_clk(core_clk),
		.rd_addr_a(rd_addr_a), .rd_addr_b(rd_addr_b), .rd_data_a(rd_data_a),
		.rd_data_b(rd_data_b), .flags_cur(flags_cur), .wr_en(wr_en),
		.wr_addr(wr_addr), .wr_data(wr_data), .flags_we(flags_we),
		.flags_out(flags_out));

	always #10 core_clk = ~core_clk;

	task automatic end_of_test();
		if (err_total == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
			err_total++;
		end
	endtask

	// carry on subtract is not-borrow
	task automatic add_sub(input logic [31:0] a, input logic [31:0] b,
		input logic sub, output logic [31:0] r, output logic c,
		output logic v);
		logic [32:0] s;
		s = sub ? {1'b0, a} + {1'b0, ~b} + 33'h1 : {1'b0, a} + {1'b0, b};
		r = s[31:0];
		c = s[32];
		v = (a[31] == (b[31] ^ sub)) && (r[31] != a[31]);
	endtask

	task automatic predict(input logic [15:0] w);
		logic [31:0] a, b, r;
		logic c, v, wb;
		logic [4:0] n;
		e_we = 1'b0;
		e_fwe = 1'b0;
		e_fgn = 1'b0;
		c = g_flg[1];
		v = g_flg[0];
		wb = 1'b1;
		r = 32'h0;
		e_addr = w[2:0];
		a = g_reg[w[5:3]];
		n = w[10:6];
		if (w[15:11] == 5'h03) begin
			e_fmt = 2'h2;
			b = w[10] ? {29'h0, w[8:6]} : g_reg[w[8:6]];
			add_sub(a, b, w[9], r, c, v);
		end else if (w[15:13] == 3'h0) begin
			e_fmt = 2'h1;
			case (w[12:11])
				2'h0: begin
					r = a << n;
					if (n != 5'h00) c = a[32 - n];
				end
				2'h1: begin
					r = (n == 5'h00) ? 32'h0 : a >> n;
					c = (n == 5'h00) ? a[31] : a[n - 1];
				end
				default: begin
					r = (n == 5'h00) ? {32{a[31]}} : 32'($signed(a) >>> n);
					c = (n == 5'h00) ? a[31] : a[n - 1];
				end
			endcase
		end else if (w[15:13] == 3'h1) begin
			e_fmt = 2'h3;
			e_addr = w[10:8];
			a = g_reg[w[10:8]];
			b = {24'h0, w[7:0]};
			if (w[12:11] == 2'h0) r = b;
			else add_sub(a, b, w[11] | ~w[12], r, c, v);
			wb = (w[12:11] != 2'h1);
		end else begin
			e_fmt = 2'h0;
			e_fgn = 1'b1;
		end
		if (!e_fgn) begin
			e_fwe = 1'b1;
			e_we = wb;
			e_data = r;
			e_flg = {r[31], r == 32'h0, c, v};
			g_flg = e_flg;
			if (wb) g_reg[e_addr] = r;
		end
	endtask

	// results of the word taken at this edge are checked half a cycle on
	task automatic step(input logic vld, input logic [15:0] w);
		logic [2:0] src_exp;
		@(posedge core_clk);
		instr_valid <= vld;
		instr <= w;
		@(negedge core_clk);
		src_exp = (w[15:13] == 3'h1) ? w[10:8] : w[5:3];
		chk({31'h0, instr_ready}, 32'h1);
		chk({29'h0, rd_addr_a}, {29'h0, src_exp});
		chk({29'h0, rd_addr_b}, {29'h0, w[8:6]});
		chk({31'h0, instr_done}, {31'h0, e_done});
		chk({31'h0, wr_en}, {31'h0, e_we});
		chk({31'h0, flags_we}, {31'h0, e_fwe});
		chk({31'h0, foreign_instr}, {31'h0, e_fgn});
		if (e_we) chk({29'h0, wr_addr}, {29'h0, e_addr});
		if (e_we) chk(wr_data, e_data);
		if (e_fwe) chk({28'h0, flags_out}, {28'h0, e_flg});
		if (e_done) chk({30'h0, exec_fmt}, {30'h0, e_fmt});
		e_done = vld;
		e_we = 1'b0;
		e_fwe = 1'b0;
		e_fgn = 1'b0;
		if (vld) predict(w);
	endtask

	function automatic logic [15:0] sh(input logic [1:0] op,
		input logic [4:0] amt, input logic [2:0] src, input logic [2:0] rd);
		return {3'h0, op, amt, src, rd};
	endfunction

	function automatic logic [15:0] as(input logic i, input logic op,
		input logic [2:0] src2, input logic [2:0] src, input logic [2:0] rd);
		return {5'h03, i, op, src2, src, rd};
	endfunction

	function automatic logic [15:0] im(input logic [1:0] op,
		input logic [2:0] rd, input logic [7:0] imm);
		return {3'h1, op, rd, imm};
	endfunction

	function automatic logic [15:0] rnd_word();
		logic [15:0] w;
		w = 16'($urandom);
		case ($urandom_range(0, 3))
			0: w[15:11] = {3'h0, 2'($urandom_range(0, 2))};
			1: w[15:11] = 5'h03;
			2: w[15:13] = 3'h1;
			default: w[15:13] = 3'($urandom_range(2, 7));
		endcase
		return w;
	endfunction

	initial begin
		void'($urandom(60478));
		repeat (8) @(posedge core_clk);
		rst <= 1'b0;
		step(1'b1, im(2'h0, 3'h0, 8'h00));
		step(1'b1, im(2'h0, 3'h1, 8'hff));
		step(1'b1, im(2'h0, 3'h2, 8'h01));
		step(1'b1, sh(2'h0, 5'h1f, 3'h2, 3'h3));
		step(1'b1, sh(2'h2, 5'h00, 3'h3, 3'h4));
		step(1'b1, sh(2'h1, 5'h00, 3'h3, 3'h5));
		step(1'b1, sh(2'h0, 5'h00, 3'h1, 3'h6));
		step(1'b1, as(1'b1, 1'b1, 3'h1, 3'h3, 3'h7));
		step(1'b1, as(1'b1, 1'b0, 3'h1, 3'h7, 3'h7));
		step(1'b1, as(1'b0, 1'b0, 3'h1, 3'h1, 3'h6));
		step(1'b1, as(1'b0, 1'b1, 3'h3, 3'h3, 3'h0));
		step(1'b1, im(2'h1, 3'h1, 8'hff));
		step(1'b1, im(2'h2, 3'h1, 8'h01));
		step(1'b1, im(2'h3, 3'h0, 8'h01));
		step(1'b1, 16'h4488);
		step(1'b1, 16'ha001);
		step(1'b1, 16'hb004);
		step(1'b1, 16'h46c0);
		step(1'b0, 16'h0000);
		repeat (1500) step($urandom_range(0, 7) != 0, rnd_word());
		step(1'b0, 16'h0000);
		end_of_test();
	end

	// the sequence needs about 1550 cycles
	initial begin
		repeat (4000) @(posedge core_clk);
		err_total++;
		end_of_test();
	end
endmodule // tb

`default_nettype wire
